// [dcc_top.sv]
// Dual comparator control: registers, result path, change flag, pins
//
// Notes on behaviour
// - Result bits 7 and 6 show comparator b and a, plus above minus.
// - Bits 5 and 4 invert comparator b and a, at pins and status.
// - In mode 110 bit 3 moves minus inputs to pins three and two.
// - Three-bit mode field selects one of seven comparator configurations; 000 and 111 are both off.
// - Internal reference feeds both plus inputs only in mode 110.
// - Reset clears control bits and sets mode 111, value 0x07.
// - Result bits are read-only; writes never change them.
// - Modes 011 and 101 switch pins four and five to raw comparator outputs.
// - Direction bits still enable the drivers of pins four and five.
// - Flag sets whenever either output differs from the latched value.
// - Flag at bit 6 clears by writing zero, writing one sets it.
// - Request needs all three enables; flag sets regardless.
// - Control register access latches outputs and ends the mismatch.
// - A change coinciding with a control read still sets the flag.
// - Comparators keep running in sleep; enabled interrupt wakes device.
// - Leaving sleep does not alter the control register.
// - Port read returns zero for every analog-configured pin.
// - After reset pins zero to three are analog, per config field.
//
// Implementation choices: the Wishbone slave port and the register addresses.
`timescale 1ns/10ps
module dcc_top (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic          [4:0] wb_adr_i,
	input  wire logic          [3:0] wb_sel_i,
	input  wire logic         [31:0] wb_dat_i,
	output logic              [31:0] wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                cmp_a_raw,
	input  wire logic                cmp_b_raw,
	input  wire logic          [5:0] pin_in,
	input  wire logic                sleep_mode,
	output dcc_pkg::dcc_route_s      route_o,
	output logic                     pin_four_sel,
	output logic                     pin_four_o,
	output logic                     pin_four_oe,
	output logic                     pin_five_sel,
	output logic                     pin_five_o,
	output logic                     pin_five_oe,
	output logic               [3:0] analog_pin_role,
	output logic                     irq_req_o,
	output logic                     wake_req_o
);

	// Register state
	logic                [5:0] ctrl_q;
	logic                [5:0] ctrl_d;
	logic                      flag_q;
	logic                      flag_d;
	logic                      cmp_irq_enable_q;
	logic                      periph_en_q;
	logic                      global_en_q;
	logic                      cmp_en_d;
	logic                      periph_en_d;
	logic                      global_en_d;
	logic                [7:0] dir_q;
	logic                [7:0] dir_d;
	logic                [3:0] pin_cfg_q;
	logic                [3:0] pin_cfg_d;
	logic                [1:0] latched_q;
	logic                [1:0] latched_d;
	logic                      ack_q;
	logic               [31:0] dat_q;
	logic                      irq_q;
	logic                      wake_q;
	dcc_pkg::dcc_route_s       route_q;
	dcc_pkg::dcc_route_s       route_d;

	// Output flops for the drive enables and pin roles
	logic                      oe_four_q;
	logic                      oe_five_q;
	logic                [3:0] role_q;

	// Decoded bus and result signals
	logic                      req;
	logic                      fire;
	logic                      wr;
	logic                      lane0;
	logic                [7:0] wbyte;
	logic                      hit_ctrl;
	logic                      hit_flag;
	logic                      hit_enable;
	logic                      hit_irq;
	logic                      hit_dir;
	logic                      hit_conv;
	logic                      hit_port;
	logic                      hit_any;
	logic                      flag_wr;
	logic                      ctrl_touch;
	logic                [1:0] raw_sync;
	// Per-comparator pairs, index 0 is comparator a
	logic                [1:0] raw_pair;
	logic                [1:0] on_pair;
	logic                [1:0] inv_pair;
	logic                [1:0] pin_pair;
	logic                      out_a;
	logic                      out_b;
	logic                [1:0] outs;
	logic                      mismatch;
	logic                [7:0] ctrl_rd;
	logic                [5:0] port_rd;
	logic                [7:0] rbyte;
	logic                [2:0] mode;
	logic                      a_inv;
	logic                      b_inv;

	// Raw comparator levels are asynchronous to the core clock
	dcc_sync #(
		.W(2)
	) u_sync (
		.core_clk(core_clk),
		.reset   (reset),
		.async_i ({cmp_b_raw, cmp_a_raw}),
		.sync_o  (raw_sync)
	);

	// Mode field and input switch decide routing and enables
	dcc_route u_route (
		.mode        (mode),
		.input_switch(ctrl_q[dcc_pkg::CTRL_SWITCH]),
		.route       (route_d)
	);

	// Control field views
	assign mode  = ctrl_q[dcc_pkg::CTRL_MODE_LSB +: 3];
	assign a_inv = ctrl_q[dcc_pkg::CTRL_A_INVERT];
	assign b_inv = ctrl_q[dcc_pkg::CTRL_B_INVERT];

	// Word address compare, shared by every register decode;
	// the full byte address must match, so odd offsets hit nothing
	function automatic logic word_hit(input logic [4:0] adr,
		input logic [4:0] offset);
		word_hit = adr == offset;
	endfunction

	// Bus request decode; ack is registered, so a write lands on the
	// edge where the master samples ack
	assign req        = wb_cyc_i & wb_stb_i;
	assign fire       = req & ack_q;
	assign wr         = fire & wb_we_i & lane0;
	assign lane0      = wb_sel_i[0];
	assign wbyte      = wb_dat_i[7:0];
	assign hit_ctrl   = word_hit(wb_adr_i, dcc_pkg::ADR_CTRL);
	assign hit_flag   = word_hit(wb_adr_i, dcc_pkg::ADR_FLAG);
	assign hit_enable = word_hit(wb_adr_i, dcc_pkg::ADR_ENABLE);
	assign hit_irq    = word_hit(wb_adr_i, dcc_pkg::ADR_IRQ_CTRL);
	assign hit_dir    = word_hit(wb_adr_i, dcc_pkg::ADR_DIR);
	assign hit_conv   = word_hit(wb_adr_i, dcc_pkg::ADR_CONV);
	assign hit_port   = word_hit(wb_adr_i, dcc_pkg::ADR_PORT);
	assign flag_wr    = wr & hit_flag;
	assign ctrl_touch = fire & hit_ctrl;
	assign hit_any    = hit_ctrl | hit_flag | hit_enable | hit_irq
		| hit_dir | hit_conv | hit_port;

	// Per-comparator views of the raw levels, enables and inversions
	assign raw_pair = {cmp_b_raw, cmp_a_raw};
	assign on_pair  = {route_q.b_on, route_q.a_on};
	assign inv_pair = {b_inv, a_inv};

	// An inactive comparator reads low before the inversion is applied.
	// The status path uses the synchronised level; the pin path takes
	// the raw one, so a pin may toggle on noise the status never sees
	for (genvar i = 0; i < 2; i++) begin : g_cmp
		assign outs[i]     = (raw_sync[i] & on_pair[i])
			^ inv_pair[i];
		assign pin_pair[i] = route_q.pins_out
			& ((raw_pair[i] & on_pair[i]) ^ inv_pair[i]);
	end
	assign out_a = outs[0];
	assign out_b = outs[1];

	// Any difference from the last latched pair is a pending change
	assign mismatch = outs != latched_q;

	// Result bits come from the comparators, never from the bus
	assign ctrl_rd = {out_b, out_a, ctrl_q};

	// Analog-configured pins read low whatever their voltage;
	// a config bit at zero marks the pin analog
	assign port_rd = {pin_in[5:4], pin_in[3:0] & pin_cfg_q};

	// Read data selection; unmapped words read zero
	assign rbyte = hit_ctrl ? ctrl_rd
		: hit_flag   ? {1'b0, flag_q, 6'h00}
		: hit_enable ? {1'b0, cmp_irq_enable_q, 6'h00}
		: hit_irq    ? {global_en_q, periph_en_q, 6'h00}
		: hit_dir    ? dir_q
		: hit_conv   ? {4'h0, pin_cfg_q}
		: hit_port   ? {2'b00, port_rd}
		: 8'h00;

	// Writes reach only bits 5 to 0; the results are not stored here
	assign ctrl_d = (wr & hit_ctrl) ? wbyte[5:0] : ctrl_q;

	// The flag follows the write, but a standing mismatch wins,
	// so an event in the clearing cycle is kept
	// A software write of one raises the flag as a simulated event
	assign flag_d = mismatch
		| (flag_wr ? wbyte[dcc_pkg::FLAG_CMP_BIT]
		: flag_q);

	// Read or write of the control word takes the current pair.
	// The comparison uses the pair before the latch, so a change in
	// the access cycle still sets the flag and is not lost
	assign latched_d = ctrl_touch ? outs
		: latched_q;

	// Bus slave: one wait state, ack dropped after one cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req & ~ack_q;
			dat_q <= {24'h00_0000, rbyte};
		end
	end

	// Control word; sleep entry and exit do not touch it
	always_ff @(posedge core_clk) begin
		if (reset) begin
			ctrl_q <= dcc_pkg::RST_CTRL[5:0];
		end else begin
			ctrl_q <= ctrl_d;
		end
	end

	// Change latch and flag
	always_ff @(posedge core_clk) begin
		if (reset) begin
			latched_q <= 2'b00;
			flag_q    <= 1'b0;
		end else begin
			latched_q <= latched_d;
			flag_q    <= flag_d;
		end
	end

	// Next values of the plain read-write words; each keeps its value
	// unless a write to its own word lands
	assign cmp_en_d    = (wr & hit_enable)
		? wbyte[dcc_pkg::ENABLE_CMP_BIT] : cmp_irq_enable_q;
	assign periph_en_d = (wr & hit_irq)
		? wbyte[dcc_pkg::IRQ_PERIPH_BIT] : periph_en_q;
	assign global_en_d = (wr & hit_irq)
		? wbyte[dcc_pkg::IRQ_GLOBAL_BIT] : global_en_q;
	assign dir_d       = (wr & hit_dir) ? wbyte : dir_q;
	assign pin_cfg_d   = (wr & hit_conv)
		? wbyte[dcc_pkg::PIN_CFG_W-1:0] : pin_cfg_q;

	// Interrupt enables
	always_ff @(posedge core_clk) begin
		if (reset) begin
			cmp_irq_enable_q <= 1'b0;
			periph_en_q      <= 1'b0;
			global_en_q      <= 1'b0;
		end else begin
			cmp_irq_enable_q <= cmp_en_d;
			periph_en_q      <= periph_en_d;
			global_en_q      <= global_en_d;
		end
	end

	// Pin direction and analog pin configuration
	always_ff @(posedge core_clk) begin
		if (reset) begin
			dir_q     <= dcc_pkg::RST_DIR;
			pin_cfg_q <= dcc_pkg::RST_PIN_CFG;
		end else begin
			dir_q     <= dir_d;
			pin_cfg_q <= pin_cfg_d;
		end
	end

	// Drive enables and pin roles leave from flops. They are built
	// from next values, so they change on the same edge as the words
	// behind them and add no lag
	always_ff @(posedge core_clk) begin
		if (reset) begin
			oe_four_q <= 1'b0;
			oe_five_q <= 1'b0;
			role_q    <= ~dcc_pkg::RST_PIN_CFG;
		end else begin
			oe_four_q <= route_d.pins_out & ~dir_d[4];
			oe_five_q <= route_d.pins_out & ~dir_d[5];
			role_q    <= ~pin_cfg_d;
		end
	end

	// Routing is registered so mode changes reach the cores cleanly.
	// Results may still swing while the cores settle on a new mode;
	// masking the interrupt across the change is left to software
	always_ff @(posedge core_clk) begin
		if (reset) begin
			route_q <= dcc_pkg::ROUTE_OFF;
		end else begin
			route_q <= route_d;
		end
	end

	// Request needs all enables; wake needs only the comparator
	// enable and sleep mode; the request is not gated by sleep
	always_ff @(posedge core_clk) begin
		if (reset) begin
			irq_q  <= 1'b0;
			wake_q <= 1'b0;
		end else begin
			irq_q  <= flag_q & cmp_irq_enable_q & periph_en_q
				& global_en_q;
			wake_q <= flag_q & cmp_irq_enable_q & sleep_mode;
		end
	end

	// Bus and status outputs
	assign wb_ack_o        = ack_q;
	assign wb_dat_o        = dat_q;
	assign route_o         = route_q;
	assign irq_req_o       = irq_q;
	assign wake_req_o      = wake_q;
	assign analog_pin_role = role_q;

	// Pin multiplexers; the data path is the unsynchronised result,
	// so it carries the comparator's own uncertainty onto the pin
	assign pin_four_sel = route_q.pins_out;
	assign pin_five_sel = route_q.pins_out;
	assign pin_four_o   = pin_pair[0];
	assign pin_five_o   = pin_pair[1];

	// A direction bit at zero drives the pin, but only in output modes
	assign pin_four_oe = oe_four_q;
	assign pin_five_oe = oe_five_q;

	// Unused bus inputs are ignored by design
	logic unused_bits;
	assign unused_bits = ^{wb_sel_i[3:1], wb_dat_i[31:8], hit_any,
		dir_q[7:6], dir_q[3:0]};

endmodule

// [dcc_pkg.sv]
// Constants, encodings and carrier types of the dual comparator control block
package dcc_pkg;

	// Byte offsets of the register words on the bus
	localparam logic [4:0] ADR_CTRL     = 5'h00;
	localparam logic [4:0] ADR_FLAG     = 5'h04;
	localparam logic [4:0] ADR_ENABLE   = 5'h08;
	localparam logic [4:0] ADR_IRQ_CTRL = 5'h0c;
	localparam logic [4:0] ADR_DIR      = 5'h10;
	localparam logic [4:0] ADR_CONV     = 5'h14;
	localparam logic [4:0] ADR_PORT     = 5'h18;

	// Field positions in comparator_control
	localparam int CTRL_B_RESULT = 7;
	localparam int CTRL_A_RESULT = 6;
	localparam int CTRL_B_INVERT = 5;
	localparam int CTRL_A_INVERT = 4;
	localparam int CTRL_SWITCH   = 3;
	localparam int CTRL_MODE_LSB = 0;

	// Field positions in the flag, enable and interrupt control words
	localparam int FLAG_CMP_BIT   = 6;
	localparam int ENABLE_CMP_BIT = 6;
	localparam int IRQ_GLOBAL_BIT = 7;
	localparam int IRQ_PERIPH_BIT = 6;

	// Width of the analog pin configuration field
	localparam int PIN_CFG_W = 4;

	// Values after reset
	localparam logic [2:0] RST_MODE    = 3'h7;
	localparam logic [7:0] RST_CTRL    = 8'h07;
	localparam logic [7:0] RST_DIR     = 8'hff;
	localparam logic [3:0] RST_PIN_CFG = 4'h0;

	// Comparator operating modes
	localparam logic [2:0] MODE_RESET   = 3'h0;
	localparam logic [2:0] MODE_ONE     = 3'h1;
	localparam logic [2:0] MODE_INDEP   = 3'h2;
	localparam logic [2:0] MODE_INDEP_O = 3'h3;
	localparam logic [2:0] MODE_COMMON  = 3'h4;
	localparam logic [2:0] MODE_COMM_O  = 3'h5;
	localparam logic [2:0] MODE_MUX_REF = 3'h6;
	localparam logic [2:0] MODE_OFF     = 3'h7;

	// Input selection codes for the analog multiplexers
	localparam logic [2:0] SEL_PIN0 = 3'h0;
	localparam logic [2:0] SEL_PIN1 = 3'h1;
	localparam logic [2:0] SEL_PIN2 = 3'h2;
	localparam logic [2:0] SEL_PIN3 = 3'h3;
	localparam logic [2:0] SEL_REF  = 3'h4;
	localparam logic [2:0] SEL_NONE = 3'h7;

	// Routing handed to the analog comparator cores
	typedef struct packed {
		logic       a_on;
		logic       b_on;
		logic       pins_out;
		logic [2:0] a_plus;
		logic [2:0] a_minus;
		logic [2:0] b_plus;
		logic [2:0] b_minus;
	} dcc_route_s;

	localparam dcc_route_s ROUTE_OFF = '{1'b0, 1'b0, 1'b0,
		SEL_NONE, SEL_NONE, SEL_NONE, SEL_NONE};

endpackage

// [dcc_sync.sv]
// Two-stage synchroniser for the asynchronous comparator results
`timescale 1ns/10ps
module dcc_sync #(
	parameter int W = 2
) (
	input  wire logic         core_clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// First stage feeds only the second stage
	always_ff @(posedge core_clk) begin
		if (reset) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= async_i;
			sync_q <= meta_q;
		end
	end

	assign sync_o = sync_q;

endmodule

// [dcc_route.sv]
// Mode decoder: comparator enables and analog input routing
`timescale 1ns/10ps
module dcc_route (
	input  wire logic              [2:0] mode,
	input  wire logic                    input_switch,
	output dcc_pkg::dcc_route_s          route
);

	// Minus inputs of the multiplexed mode follow the input switch
	logic [2:0] mux_a_minus;
	logic [2:0] mux_b_minus;

	assign mux_a_minus = input_switch ? dcc_pkg::SEL_PIN3
		: dcc_pkg::SEL_PIN0;
	assign mux_b_minus = input_switch ? dcc_pkg::SEL_PIN2
		: dcc_pkg::SEL_PIN1;

	// One configuration per mode code
	always_comb begin
		route = dcc_pkg::ROUTE_OFF;
		unique case (mode)
			dcc_pkg::MODE_RESET, dcc_pkg::MODE_OFF: begin
				route = dcc_pkg::ROUTE_OFF;
			end
			dcc_pkg::MODE_ONE: begin
				route.a_on    = 1'b1;
				route.a_minus = dcc_pkg::SEL_PIN0;
				route.a_plus  = dcc_pkg::SEL_PIN3;
			end
			dcc_pkg::MODE_INDEP, dcc_pkg::MODE_INDEP_O: begin
				route.a_on     = 1'b1;
				route.b_on     = 1'b1;
				route.pins_out = mode[0];
				route.a_minus  = dcc_pkg::SEL_PIN0;
				route.a_plus   = dcc_pkg::SEL_PIN3;
				route.b_minus  = dcc_pkg::SEL_PIN1;
				route.b_plus   = dcc_pkg::SEL_PIN2;
			end
			dcc_pkg::MODE_COMMON, dcc_pkg::MODE_COMM_O: begin
				route.a_on     = 1'b1;
				route.b_on     = 1'b1;
				route.pins_out = mode[0];
				route.a_minus  = dcc_pkg::SEL_PIN0;
				route.a_plus   = dcc_pkg::SEL_PIN2;
				route.b_minus  = dcc_pkg::SEL_PIN1;
				route.b_plus   = dcc_pkg::SEL_PIN2;
			end
			dcc_pkg::MODE_MUX_REF: begin
				route.a_on    = 1'b1;
				route.b_on    = 1'b1;
				route.a_minus = mux_a_minus;
				route.b_minus = mux_b_minus;
				route.a_plus  = dcc_pkg::SEL_REF;
				route.b_plus  = dcc_pkg::SEL_REF;
			end
		endcase
	end

endmodule

// [dcc_assertions.sv]
// Port checker for the dual comparator control block
`timescale 1ns/10ps
module dcc_checker (
	input  wire logic                core_clk,
	input  wire logic                reset,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic          [4:0] wb_adr_i,
	input  wire logic          [3:0] wb_sel_i,
	input  wire logic         [31:0] wb_dat_i,
	input  wire logic                wb_ack_o,
	input  wire logic                cmp_a_raw,
	input  wire logic                sleep_mode,
	input  wire dcc_pkg::dcc_route_s route_o,
	input  wire logic                pin_four_sel,
	input  wire logic                pin_four_o,
	input  wire logic                pin_four_oe,
	input  wire logic                pin_five_oe,
	input  wire logic          [3:0] analog_pin_role,
	input  wire logic                irq_req_o,
	input  wire logic                wake_req_o
);
	logic [7:0] sh_q [8];
	wire        wr_hit;
	wire  [2:0] mode_w;

	// A write lands on the edge that samples ack
	assign wr_hit = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
	assign mode_w = sh_q[0][2:0];

	// Shadow of the writable words, so gating can be judged at the ports
	always_ff @(posedge core_clk) begin
		if (reset)
			sh_q <= '{8'h07, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00};
		else if (wr_hit)
			sh_q[wb_adr_i[4:2]] <= wb_dat_i[7:0];
	end

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	a_reset_idle: assert property (disable iff (1'b0)
		reset |=> route_o == dcc_pkg::ROUTE_OFF && !irq_req_o
		&& analog_pin_role == 4'hf && !pin_four_sel)
		else $error("outputs not idle after reset");
	a_ack_pulse: assert property (
		wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not a one-cycle answer");
	a_drive_enable: assert property (
		pin_four_oe == (route_o.pins_out & ~sh_q[4][4])
		&& pin_five_oe == (route_o.pins_out & ~sh_q[4][5]))
		else $error("pin drive enable wrong");
	a_pin_invert: assert property (
		pin_four_sel |-> pin_four_o == (cmp_a_raw ^ sh_q[0][4]))
		else $error("pin output not the raw result");
	// Either side of the route register lag is accepted
	a_ref_both: assert property (
		route_o.a_plus == dcc_pkg::SEL_REF |->
		route_o.b_plus == dcc_pkg::SEL_REF
		&& ($past(mode_w) == 3'h6 || mode_w == 3'h6))
		else $error("reference used outside mux mode");
	a_switch_minus: assert property (
		route_o.a_minus == dcc_pkg::SEL_PIN3 |->
		route_o.b_minus == dcc_pkg::SEL_PIN2
		&& route_o.a_plus == dcc_pkg::SEL_REF)
		else $error("switched minus inputs wrong");
	a_off_mode: assert property (
		$past(mode_w) == 3'h7 && mode_w == 3'h7 |->
		!route_o.a_on && !route_o.b_on)
		else $error("comparator on in off mode");
	a_irq_gate: assert property (
		irq_req_o |-> $past(sh_q[2][6] & sh_q[3][7] & sh_q[3][6]))
		else $error("request without all enables");
	a_wake_sleep: assert property (
		wake_req_o |-> $past(sleep_mode & sh_q[2][6]))
		else $error("wake outside sleep or disabled");
	a_pin_role: assert property (
		analog_pin_role == ~sh_q[5][3:0])
		else $error("analog pin role wrong");
endmodule

bind dcc_top dcc_checker u_chk (
	.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
	.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o),
	.cmp_a_raw(cmp_a_raw), .sleep_mode(sleep_mode), .route_o(route_o),
	.pin_four_sel(pin_four_sel), .pin_four_o(pin_four_o),
	.pin_four_oe(pin_four_oe), .pin_five_oe(pin_five_oe),
	.analog_pin_role(analog_pin_role), .irq_req_o(irq_req_o),
	.wake_req_o(wake_req_o));

// [dcc_cmp_model.sv]
// Behavioural pair of analog comparators steered by the routing word
`timescale 1ns/10ps
module dcc_cmp_model (
	input  wire logic                core_clk,
	input  wire dcc_pkg::dcc_route_s route,
	input  wire logic     [7:0][7:0] level,
	output logic                     cmp_a_raw,
	output logic                     cmp_b_raw
);
	logic idle_q = 1'b0;

	// A powered-down core has no defined output, so it wanders each cycle
	always_ff @(posedge core_clk) begin
		idle_q <= ~idle_q;
	end

	// High when plus lies above minus, from whichever inputs are routed
	assign cmp_a_raw = route.a_on ? (level[route.a_plus] >
		level[route.a_minus]) : idle_q;
	assign cmp_b_raw = route.b_on ? (level[route.b_plus] >
		level[route.b_minus]) : ~idle_q;
endmodule

// [dcc_top_test.sv]
// Self-checking bench for the dual comparator control block
`timescale 1ns/10ps
module dcc_top_test;
	logic                core_clk = 1'b0;
	logic                reset = 1'b1;
	logic                wb_cyc_i = 1'b0;
	logic                wb_stb_i = 1'b0;
	logic                wb_we_i = 1'b0;
	logic          [4:0] wb_adr_i = 5'h00;
	logic          [3:0] wb_sel_i = 4'h1;
	logic         [31:0] wb_dat_i = 32'h0;
	logic          [5:0] pin_in = 6'h00;
	logic                sleep_mode = 1'b0;
	logic     [7:0][7:0] level = '0;
	logic         [31:0] wb_dat_o;
	logic                wb_ack_o, cmp_a_raw, cmp_b_raw;
	logic                pin_four_sel, pin_four_o, pin_four_oe;
	logic                pin_five_sel, pin_five_o, pin_five_oe;
	logic          [3:0] analog_pin_role;
	logic                irq_req_o, wake_req_o;
	dcc_pkg::dcc_route_s route_o;
	int                  n_errors = 0;
	int                  check_count = 0;

	dcc_top uut (
		.core_clk(core_clk), .reset(reset), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw),
		.pin_in(pin_in), .sleep_mode(sleep_mode), .route_o(route_o),
		.pin_four_sel(pin_four_sel), .pin_four_o(pin_four_o),
		.pin_four_oe(pin_four_oe), .pin_five_sel(pin_five_sel),
		.pin_five_o(pin_five_o), .pin_five_oe(pin_five_oe),
		.analog_pin_role(analog_pin_role), .irq_req_o(irq_req_o),
		.wake_req_o(wake_req_o));
	dcc_cmp_model far (.core_clk(core_clk), .route(route_o), .level(level),
		.cmp_a_raw(cmp_a_raw), .cmp_b_raw(cmp_b_raw));

	// Clock of 4 ns period
	always #2 core_clk = ~core_clk;

	task automatic conclude;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One classic cycle; ack is sampled on the rising edge, where the
	// read data is taken and the request released
	task automatic bus(input logic we, input logic [4:0] a,
		input logic [7:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		@(posedge core_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= {24'h0, d};
		do begin
			@(posedge core_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		rd = wb_dat_o;
		if (n >= 50)
			chk(32'h0, 32'h1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		logic [31:0] rd;
		bus(1'b1, a, d, rd);
	endtask

	task automatic rdc(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		bus(1'b0, a, 8'h00, rd);
		chk(rd, exp);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge core_clk);
		@(negedge core_clk);
	endtask

	// Reference routing per mode and switch
	function automatic dcc_pkg::dcc_route_s eroute(input logic [2:0] m,
		input logic s);
		eroute = dcc_pkg::ROUTE_OFF;
		case (m)
		3'h1: eroute = '{1'h1, 1'h0, 1'h0, 3'h3, 3'h0, 3'h7, 3'h7};
		3'h2, 3'h3: eroute = '{1'h1, 1'h1, m[0], 3'h3, 3'h0, 3'h2, 3'h1};
		3'h4, 3'h5: eroute = '{1'h1, 1'h1, m[0], 3'h2, 3'h0, 3'h2, 3'h1};
		3'h6: eroute = '{1'h1, 1'h1, 1'h0, 3'h4, s ? 3'h3 : 3'h0, 3'h4,
			s ? 3'h2 : 3'h1};
		default: ;
		endcase
	endfunction

	// Plus above minus for each routed comparator; off reads low
	function automatic logic [1:0] eres(input dcc_pkg::dcc_route_s r);
		eres[1] = r.b_on && level[r.b_plus] > level[r.b_minus];
		eres[0] = r.a_on && level[r.a_plus] > level[r.a_minus];
	endfunction

	// A hang ends the run as a mismatch
	initial begin
		#100000;
		n_errors++;
		conclude();
	end

	initial begin
		dcc_pkg::dcc_route_s er;
		logic [7:0] c;
		logic [5:0] p;
		void'($urandom(13599));
		repeat (5) @(posedge core_clk);
		reset <= 1'b0;
		rdc(dcc_pkg::ADR_CTRL, 32'h07);
		rdc(dcc_pkg::ADR_CONV, 32'h00);
		rdc(5'h1c, 32'h00);
		chk({28'h0, analog_pin_role}, 32'hf);
		// Every mode, random levels, inversions and switch
		for (int m = 0; m < 8; m++) begin
			for (int k = 0; k < 3; k++) begin
				level <= {$urandom, $urandom};
				c = {2'h3, 2'($urandom), k[0], 3'(m)};
				wr(dcc_pkg::ADR_CTRL, c);
				settle(4);
				er = eroute(c[2:0], c[3]);
				chk({15'h0, route_o, pin_four_sel, pin_five_sel},
					{15'h0, er, er.pins_out, er.pins_out});
				rdc(dcc_pkg::ADR_CTRL, {24'h0, eres(er) ^ c[5:4], c[5:0]});
			end
		end
		// Change flag, mismatch latch, enables and sleep
		level <= 64'h00000000ff000000;
		wr(dcc_pkg::ADR_CTRL, 8'h02);
		settle(4);
		rdc(dcc_pkg::ADR_CTRL, 32'h42);
		wr(dcc_pkg::ADR_FLAG, 8'h00);
		rdc(dcc_pkg::ADR_FLAG, 32'h00);
		wr(dcc_pkg::ADR_ENABLE, 8'h40);
		wr(dcc_pkg::ADR_IRQ_CTRL, 8'hc0);
		level <= '0;
		settle(6);
		chk({31'h0, irq_req_o}, 32'h1);
		wr(dcc_pkg::ADR_FLAG, 8'h00);
		rdc(dcc_pkg::ADR_FLAG, 32'h40);
		rdc(dcc_pkg::ADR_CTRL, 32'h02);
		wr(dcc_pkg::ADR_FLAG, 8'h00);
		rdc(dcc_pkg::ADR_FLAG, 32'h00);
		wr(dcc_pkg::ADR_FLAG, 8'h40);
		rdc(dcc_pkg::ADR_FLAG, 32'h40);
		wr(dcc_pkg::ADR_IRQ_CTRL, 8'h40);
		sleep_mode <= 1'b1;
		settle(3);
		chk({30'h0, irq_req_o, wake_req_o}, 32'h1);
		rdc(dcc_pkg::ADR_CTRL, 32'h02);
		sleep_mode <= 1'b0;
		// Comparator outputs on the port pins
		level <= 64'h00000000ff000000;
		wr(dcc_pkg::ADR_CTRL, 8'h33);
		wr(dcc_pkg::ADR_DIR, 8'hcf);
		settle(4);
		chk({pin_five_oe, pin_four_oe, pin_five_o, pin_four_o}, 32'he);
		wr(dcc_pkg::ADR_DIR, 8'hff);
		settle(2);
		chk({pin_five_oe, pin_four_oe}, 32'h0);
		// Analog-configured pins read low
		p = 6'($urandom);
		@(posedge core_clk);
		pin_in <= p;
		wr(dcc_pkg::ADR_CONV, 8'h05);
		settle(3);
		chk({28'h0, analog_pin_role}, 32'ha);
		rdc(dcc_pkg::ADR_PORT, {26'h0, p[5:4], p[3:0] & 4'h5});
		conclude();
	end
endmodule
